// >>> hw/spi_port_consts.vh
// Constants for the serial peripheral port
`ifndef SPI_PORT_CONSTS_VH
`define SPI_PORT_CONSTS_VH
`define BYTE_BITS 4'h8
`define RATE_DIV_00 6'h02
`define RATE_DIV_01 6'h04
`define RATE_DIV_10 6'h10
`define RATE_DIV_11 6'h20
`define SS_DDR_BIT 3'h5
`define SYNC_RST 3'h7
`endif

// >>> hw/spi_master_slave_port.v
// Serial peripheral port, master or slave, one byte full duplex
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_consts.vh"
module spi_master_slave_port #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Control
  input wire port_enable_bit,
  input wire master_select_bit,
  input wire port_interrupt_enable,
  input wire cpol,
  input wire cpha,
  input wire rate_select_low,
  input wire rate_select_high,
  input wire ctrl_write,
  input wire [7:0] port_d_direction_reg,
  // Data register access
  input wire data_write,
  input wire [WIDTH-1:0] data_wdata,
  input wire status_clear,
  // Status
  output wire [WIDTH-1:0] serial_data_reg,
  output wire transfer_done_flag,
  output wire mode_fault_flag,
  output wire enable_active,
  output wire master_active,
  output wire irq,
  output wire busy,
  // Pins
  input wire miso_in,
  output wire miso_out,
  output wire miso_oe,
  input wire mosi_in,
  output wire mosi_out,
  output wire mosi_oe,
  input wire sck_in,
  output wire sck_out,
  output wire sck_oe,
  input wire ss_n_in
);

  // ------------------------------------------------------------
  // Mode state and synchronisers
  // ------------------------------------------------------------
  reg en_r;
  reg master_select_bit_r;
  reg [2:0] sck_s_r;
  reg [2:0] ss_s_r;
  reg [2:0] mosi_s_r;
  reg sck_q_r;
  reg ss_q_r;
  wire sck_f;
  wire ss_f;
  wire is_master;
  wire is_slave;

  assign is_master = en_r & master_select_bit_r;
  assign is_slave = en_r & ~master_select_bit_r;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_s_r <= `SYNC_RST;
      ss_s_r <= `SYNC_RST;
      mosi_s_r <= `SYNC_RST;
    end else begin
      sck_s_r <= {sck_s_r[1:0], sck_in};
      ss_s_r <= {ss_s_r[1:0], ss_n_in};
      mosi_s_r <= {mosi_s_r[1:0], mosi_in};
    end
  end

  // Accept a change only when stages two and three agree
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_q_r <= 1'b0;
      ss_q_r <= 1'b1;
    end else begin
      if (sck_s_r[1] == sck_s_r[2])
        sck_q_r <= sck_s_r[2];
      if (ss_s_r[1] == ss_s_r[2])
        ss_q_r <= ss_s_r[2];
    end
  end
  assign sck_f = sck_q_r;
  assign ss_f = ss_q_r;

  // ------------------------------------------------------------
  // Master clock divider
  // ------------------------------------------------------------
  function [5:0] rate_div;
    input [1:0] code;
    begin
      case (code)
        2'h0: rate_div = `RATE_DIV_00;
        2'h1: rate_div = `RATE_DIV_01;
        2'h2: rate_div = `RATE_DIV_10;
        default: rate_div = `RATE_DIV_11;
      endcase
    end
  endfunction

  localparam ST_IDLE = 2'h0;
  localparam ST_LEAD = 2'h1;
  localparam ST_TRAIL = 2'h2;

  reg [1:0] st_r;
  reg [4:0] div_cnt_r;
  reg [3:0] bit_cnt_r;
  reg sck_r;
  reg [WIDTH-1:0] shift_r;
  reg [WIDTH-1:0] rbuf_r;
  reg done_r;
  reg mode_fault_flag_r;
  reg in_bit_r;
  wire [5:0] full_div;
  wire [4:0] half_div;
  wire half_tick;
  wire ss_gpo;

  // Half period in clocks; divide by 2 gives one clock per half
  assign full_div = rate_div({rate_select_high, rate_select_low});
  assign half_div = full_div[5:1];
  assign half_tick = (div_cnt_r == half_div - 5'h01);
  assign ss_gpo = port_d_direction_reg[`SS_DDR_BIT];

  // ------------------------------------------------------------
  // Slave edge detection
  // ------------------------------------------------------------
  reg sck_d_r;
  reg ss_d_r;
  wire sck_lvl;
  wire s_lead;
  wire s_trail;
  wire ss_fall;
  wire ss_rise;
  wire s_sel;

  // Clock edges count only while select is low, so a raised select blocks edges
  assign sck_lvl = sck_f ^ cpol;
  assign s_sel = ~ss_f;
  assign s_lead = s_sel & sck_lvl & ~sck_d_r;
  assign s_trail = s_sel & ~sck_lvl & sck_d_r;
  assign ss_fall = ~ss_f & ss_d_r;
  assign ss_rise = ss_f & ~ss_d_r;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_d_r <= 1'b0;
      ss_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_lvl;
      ss_d_r <= ss_f;
    end
  end

  // ------------------------------------------------------------
  // Shift engine
  // ------------------------------------------------------------
  wire wr_ok;
  wire ms_fault;
  assign wr_ok = data_write & (st_r == ST_IDLE) & (bit_cnt_r == 4'h0);
  // Fault detection off when select pin is a general output
  assign ms_fault = is_master & ~ss_f & ~ss_gpo;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      div_cnt_r <= 5'h00;
      bit_cnt_r <= 4'h0;
      sck_r <= 1'b0;
      shift_r <= {WIDTH{1'b0}};
      rbuf_r <= {WIDTH{1'b0}};
      done_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      in_bit_r <= 1'b0;
      en_r <= 1'b0;
      master_select_bit_r <= 1'b0;
    end else begin
      if (ctrl_write) begin
        en_r <= port_enable_bit;
        master_select_bit_r <= master_select_bit;
      end
      // Set wins over software clear
      if (status_clear)
        done_r <= 1'b0;
      if (ctrl_write)
        mode_fault_flag_r <= 1'b0;
      if (ms_fault) begin
        mode_fault_flag_r <= 1'b1;
        en_r <= 1'b0;
        master_select_bit_r <= 1'b0;
        st_r <= ST_IDLE;
        bit_cnt_r <= 4'h0;
      end else if (is_master) begin
        case (st_r)
          ST_IDLE: begin
            if (wr_ok) begin
              shift_r <= data_wdata;
              div_cnt_r <= 5'h00;
              bit_cnt_r <= 4'h0;
              st_r <= ST_LEAD;
            end
          end
          // MISO answers our own clock, so it is taken straight from the pin;
          // a three-stage synchroniser would lag one and a half bits at divide by 2
          ST_LEAD: begin
            // Data has stood a half period before this edge
            if (half_tick) begin
              div_cnt_r <= 5'h00;
              sck_r <= 1'b1;
              if (!cpha)
                in_bit_r <= miso_in;
              else if (bit_cnt_r != 4'h0)
                shift_r <= {shift_r[WIDTH-2:0], in_bit_r};
              st_r <= ST_TRAIL;
            end else begin
              div_cnt_r <= div_cnt_r + 5'h01;
            end
          end
          ST_TRAIL: begin
            if (half_tick) begin
              div_cnt_r <= 5'h00;
              sck_r <= 1'b0;
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (!cpha)
                shift_r <= {shift_r[WIDTH-2:0], in_bit_r};
              else
                in_bit_r <= miso_in;
              if (bit_cnt_r + 4'h1 == `BYTE_BITS) begin
                st_r <= ST_IDLE;
                bit_cnt_r <= 4'h0;
                done_r <= 1'b1;
                rbuf_r <= {shift_r[WIDTH-2:0], cpha ? miso_in : in_bit_r};
              end else begin
                st_r <= ST_LEAD;
              end
            end else begin
              div_cnt_r <= div_cnt_r + 5'h01;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end else if (is_slave) begin
        sck_r <= 1'b0;
        st_r <= ST_IDLE;
        // Slave loads but never starts; the master clocks it out
        if (wr_ok & ss_f)
          shift_r <= data_wdata;
        if (ss_rise & ~cpha)
          bit_cnt_r <= 4'h0;
        if (s_lead) begin
          if (cpha) begin
            // Counter only clears at byte end, so select may stay low
            shift_r <= {shift_r[WIDTH-2:0], mosi_s_r[2]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else begin
            in_bit_r <= mosi_s_r[2];
          end
        end
        if (s_trail & ~cpha) begin
          shift_r <= {shift_r[WIDTH-2:0], in_bit_r};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        if (((s_trail & ~cpha) | (s_lead & cpha)) & (bit_cnt_r == `BYTE_BITS - 4'h1)) begin
          done_r <= 1'b1;
          bit_cnt_r <= 4'h0;
          rbuf_r <= cpha ? {shift_r[WIDTH-2:0], mosi_s_r[2]} : {shift_r[WIDTH-2:0], in_bit_r};
        end
      end else begin
        st_r <= ST_IDLE;
        sck_r <= 1'b0;
        bit_cnt_r <= 4'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // Pins and status
  // ------------------------------------------------------------
  // Slave shows MSB from select fall in both phases; phase one shifts it out at the first edge
  reg miso_bit_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      miso_bit_r <= 1'b0;
    else
      miso_bit_r <= shift_r[WIDTH-1];
  end
  wire ddr_miso;
  wire ddr_mosi;
  wire ddr_sck;
  assign ddr_miso = port_d_direction_reg[2];
  assign ddr_mosi = port_d_direction_reg[3];
  assign ddr_sck = port_d_direction_reg[4];

  assign miso_out = miso_bit_r;
  assign miso_oe = is_slave & s_sel & ddr_miso;
  assign mosi_out = shift_r[WIDTH-1];
  assign mosi_oe = is_master & ddr_mosi;
  assign sck_out = sck_r ^ cpol;
  assign sck_oe = is_master & ddr_sck;
  assign serial_data_reg = rbuf_r;
  assign transfer_done_flag = done_r;
  assign mode_fault_flag = mode_fault_flag_r;
  assign enable_active = en_r;
  assign master_active = master_select_bit_r;
  assign irq = port_interrupt_enable & (done_r | mode_fault_flag_r);
  assign busy = (st_r != ST_IDLE) | (bit_cnt_r != 4'h0);

endmodule // spi_master_slave_port
`default_nettype wire

// >>> verification/spi_port_monitor.sv
// Checker for the serial port, bound to the port's top module
`timescale 1ns/1ps
`default_nettype none
module spi_port_monitor (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Control and status
  input wire port_interrupt_enable,
  input wire cpol,
  input wire [7:0] port_d_direction_reg,
  input wire data_write,
  input wire transfer_done_flag,
  input wire mode_fault_flag,
  input wire enable_active,
  input wire master_active,
  input wire irq,
  input wire busy,
  // Pins
  input wire ss_n_in,
  input wire miso_oe,
  input wire mosi_oe,
  input wire sck_out,
  input wire sck_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_irq_source: assert property (irq == (port_interrupt_enable && (transfer_done_flag || mode_fault_flag)))
    else $error("irq does not follow its flags");
  a_fault_drops_mode: assert property ($rose(mode_fault_flag) |-> ##[0:1] (!enable_active && !master_active))
    else $error("mode fault left port enabled or master");
  a_fault_on_select: assert property ((enable_active && master_active && !port_d_direction_reg[5] && !ss_n_in)[*3]
    |-> ##[0:3] mode_fault_flag)
    else $error("select low in master gave no mode fault");
  a_idle_sck_level: assert property (enable_active && master_active && !busy && sck_oe && $stable(cpol) |-> sck_out == cpol)
    else $error("idle clock level differs from polarity");
  a_slave_floats: assert property ((!master_active && ss_n_in)[*8] |-> !miso_oe)
    else $error("unselected slave drives miso");
  a_master_miso_in: assert property (master_active |-> !miso_oe && !(enable_active && sck_oe && !master_active))
    else $error("master drives miso");
  a_oe_needs_ddr: assert property ((mosi_oe |-> port_d_direction_reg[3]) and (sck_oe |-> port_d_direction_reg[4])
    and (miso_oe |-> port_d_direction_reg[2]))
    else $error("pin driven with direction bit clear");
  a_write_starts: assert property (data_write && !busy && master_active && enable_active |=> busy[*8])
    else $error("master write did not start a transfer");
endmodule // spi_port_monitor
bind spi_master_slave_port spi_port_monitor i_spi_port_monitor (.*);
`default_nettype wire

// >>> verification/spi_slave_model.sv
// Behavioural slave at the far end of the port
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  // Serial pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  // Setup and captured byte
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  logic [7:0] sh = 8'h00;
  integer got = 0;
  // Released line shows the inverse, so a stale bit cannot pass
  assign miso = sel_n ? ~sh[7] : sh[7];
  always @(negedge sel_n) begin
    sh = tx;
    got = 0;
  end
  always @(sck) if (!sel_n) begin
    if ((sck != cpol) ^ cpha) begin
      rx = {rx[6:0], mosi};
      got = got + 1;
    end else if (cpha == 1'b0 || got > 0) begin
      sh = {sh[6:0], 1'b0};
    end
  end
endmodule // spi_slave_model
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rstn = 0, en = 0, ms = 0, ie = 0, cpol = 0, cpha = 0, rs0 = 0, rs1 = 0;
  logic cw = 0, dw = 0, sc = 0, ss_n = 1, sel_n = 1;
  logic [7:0] ddr = 8'h1C, wd = 8'h00, stx = 8'h00;
  wire [7:0] rd, srx;
  wire done, fault, ena, msa, irq, busy, miso_o, miso_oe, mosi_o, mosi_oe, sck_o, sck_oe, miso_w;
  wire mosi_w = mosi_oe ? mosi_o : 1'b1;
  wire sck_w = sck_oe ? sck_o : cpol;
  integer failures = 0, checked = 0, seed = 32'h84036130, edges = 0, t, m, r, dv;
  always #25 clk = ~clk;
  always @(sck_w) if (!sel_n) edges = edges + 1;
  spi_master_slave_port i_spi_master_slave_port (.clk(clk), .rstn(rstn), .port_enable_bit(en),
    .master_select_bit(ms), .port_interrupt_enable(ie), .cpol(cpol), .cpha(cpha), .rate_select_low(rs0),
    .rate_select_high(rs1), .ctrl_write(cw), .port_d_direction_reg(ddr), .data_write(dw), .data_wdata(wd),
    .status_clear(sc), .serial_data_reg(rd), .transfer_done_flag(done), .mode_fault_flag(fault),
    .enable_active(ena), .master_active(msa), .irq(irq), .busy(busy), .miso_in(miso_w), .miso_out(miso_o),
    .miso_oe(miso_oe), .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe(mosi_oe), .sck_in(sck_w),
    .sck_out(sck_o), .sck_oe(sck_oe), .ss_n_in(ss_n));
  spi_slave_model i_spi_slave_model (.sck(sck_w), .mosi(mosi_w), .sel_n(sel_n), .miso(miso_w),
    .cpol(cpol), .cpha(cpha), .tx(stx), .rx(srx));
  task check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task close_out;
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task ctrl(input logic e, input logic mm);
    @(negedge clk);
    en = e;
    ms = mm;
    cw = 1;
    @(negedge clk);
    cw = 0;
  endtask
  task xfer(input integer mode, input integer rate);
    @(negedge clk);
    {cpol, cpha} = mode[1:0];
    {rs1, rs0} = rate[1:0];
    wd = $random(seed);
    stx = $random(seed);
    dv = (rate == 0) ? 2 : (rate == 1) ? 4 : (rate == 2) ? 16 : 32;
    @(negedge clk);
    edges = 0;
    sel_n = 0;
    dw = 1;
    @(negedge clk);
    dw = 0;
    t = 1;
    while (done !== 1'b1 && t < 2000) begin
      @(negedge clk);
      t = t + 1;
    end
    check8("latency", 8'h01, (t >= 8 * dv && t <= 8 * dv + 3));
    check8("master rx", stx, rd);
    check8("slave rx", wd, srx);
    check8("sck edges", 8'h10, edges[7:0]);
    check8("sck idle", {7'h00, cpol}, {7'h00, sck_o});
    sel_n = 1;
    sc = 1;
    @(negedge clk);
    sc = 0;
    check8("done clear", 8'h00, {7'h00, done});
  endtask
  initial begin
    #(50 * 60000);
    failures = failures + 1;
    close_out;
  end
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1;
    ctrl(1, 1);
    for (m = 0; m < 4; m = m + 1)
      for (r = 0; r < 4; r = r + 1) xfer(m, r);
    // Slave: unselected floats, selected drives, never makes the clock
    ctrl(1, 0);
    repeat (8) @(negedge clk);
    check8("slave oe", 8'h00, {6'h00, miso_oe, sck_oe});
    ss_n = 0;
    repeat (8) @(negedge clk);
    check8("slave sel oe", 8'h02, {6'h00, miso_oe, sck_oe});
    ss_n = 1;
    // Master with select pulled low
    ie = 1;
    ctrl(1, 1);
    ss_n = 0;
    repeat (8) @(negedge clk);
    check8("fault", 8'h09, {4'h0, fault, ena, msa, irq});
    ss_n = 1;
    ddr = 8'h3C;
    ctrl(1, 1);
    ss_n = 0;
    repeat (8) @(negedge clk);
    check8("no fault", 8'h06, {4'h0, fault, ena, msa, irq});
    ss_n = 1;
    ddr = 8'h00;
    repeat (4) @(negedge clk);
    check8("ddr off", 8'h00, {6'h00, mosi_oe, sck_oe});
    close_out;
  end
endmodule // tb
`default_nettype wire
